// >>> srs_cfg.svh
// constants for the self-test, random and supply-switch register bank
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define SRS_IDX_RANDOM 16'h6105
`define SRS_IDX_CTRL 16'h6106
`define SRS_IDX_TEST 16'h610C
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SRS_TEST_EN 0
`define SRS_TEST_HIGH_LSB 1
`define SRS_TEST_LOW_LSB 4
`define SRS_TEST_OVER 6
`define SRS_TEST_UNDER 7
`define SRS_CTRL_READY 1
`define SRS_CTRL_RUN 2
`define SRS_CTRL_SWITCH 4
`define SRS_CTRL_OVERLOAD 5
`define SRS_CTRL_HIDE 6
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SRS_RST_CTRL 8'h41
`define SRS_RST_TEST 8'h00
`define SRS_RST_RANDOM 8'h00
// ----------------------------------------------------------------------
// thresholds in mA
// ----------------------------------------------------------------------
`define SRS_LOW_THR {8'h28, 8'h1D, 8'h12, 8'h06}
`define SRS_HIGH_THR {8'h7F, 8'h73, 8'h66, 8'h59, 8'h4C, 8'h40, 8'h32, 8'h26}
`endif

// >>> srs_pkg.sv
// types for the self-test, random and supply-switch register bank
package srs_pkg;
  // ----------------------------------------------------------------------
  // avalon-mm request and response
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } srs_av_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } srs_av_rsp_s;
  // ----------------------------------------------------------------------
  // secure-chip pad inputs and their internal copies
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic secure_chip_signal_input;
    logic auxiliary_port_pin;
  } srs_pads_s;
endpackage

// >>> srs_ctrl.sv
// register bank: antenna self test, random value, secure-chip supply switch
//
// Notes on behaviour
// - with test enable bit 0 set the supply current is compared with both thresholds.
// - bit 7 of the test register flags a current below the low threshold.
// - bit 6 of the test register flags a current above the high threshold.
// - bits 5..4 pick the low threshold 6, 18, 29 or 40 mA.
// - bits 3..1 pick the high threshold from 38 mA up to 127 mA in eight steps.
// - the test result leaves the block only through the register flags.
// - the random register holds an 8-bit value and is writable.
// - the ready flag in control bit 1 rises whenever a fresh value lands.
// - reading the random register clears the ready flag by itself.
// - control bit 2 forces the source to run, else the interface unit decides.
// - with control bit 6 set the signal copy is 0 and the port copy is 1.
// - control bit 4 turns the secure-chip supply switch on.
// - read-only control bit 5 shows the switch current limiter.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "srs_cfg.svh"
module srs_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire srs_pkg::srs_av_req_s av_req,
  output srs_pkg::srs_av_rsp_s av_rsp,
  input wire logic [7:0] transmitter_supply_ma,
  input wire logic [7:0] rng_data,
  input wire logic rng_valid,
  input wire logic contactless_interface_unit_rng_req,
  output logic rng_run,
  input wire srs_pkg::srs_pads_s pads,
  output srs_pkg::srs_pads_s pads_int,
  input wire logic switch_overload,
  output logic supply_switch_en
);
  import srs_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // the current reading is slow against the core clock, so a plain
  // two-stage crossing is enough; a glitchy word only costs one sample
  logic [7:0] cur_meta;
  logic [7:0] cur_s;
  srs_pads_s pads_meta;
  srs_pads_s pads_s;
  logic ovl_meta;
  logic ovl_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_meta <= 8'h00;
      cur_s <= 8'h00;
    end else begin
      cur_meta <= transmitter_supply_ma;
      cur_s <= cur_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pads_meta <= 2'h0;
      pads_s <= 2'h0;
      ovl_meta <= 1'b0;
      ovl_s <= 1'b0;
    end else begin
      pads_meta <= pads;
      pads_s <= pads_meta;
      ovl_meta <= switch_overload;
      ovl_s <= ovl_meta;
    end
  end

  // ----------------------------------------------------------------------
  // avalon-mm slave, one wait state on every access
  // ----------------------------------------------------------------------
  logic ack;
  logic req;
  logic aligned;
  logic hit_random;
  logic hit_ctrl;
  logic hit_test;
  logic wr_random;
  logic wr_ctrl;
  logic wr_test;
  logic rd_random;
  logic [7:0] rd_mux;
  logic [31:0] readdata;

  assign req = av_req.read | av_req.write;
  assign aligned = av_req.address[1:0] == 2'h0;
  assign hit_random = aligned && av_req.address[17:2] == `SRS_IDX_RANDOM;
  assign hit_ctrl = aligned && av_req.address[17:2] == `SRS_IDX_CTRL;
  assign hit_test = aligned && av_req.address[17:2] == `SRS_IDX_TEST;
  // only the low byte lane carries register bits
  assign wr_random = ack && av_req.write && av_req.byteenable[0] && hit_random;
  assign wr_ctrl = ack && av_req.write && av_req.byteenable[0] && hit_ctrl;
  assign wr_test = ack && av_req.write && av_req.byteenable[0] && hit_test;
  assign rd_random = ack && av_req.read && hit_random;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // one driver for the whole response word
  assign av_rsp = {readdata, req && !ack};

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0] random_value;
  logic ready;
  logic cpu_need_rng;
  logic switch_en;
  logic hide;
  logic test_en;
  logic [1:0] low_sel;
  logic [2:0] high_sel;
  logic under;
  logic over;
  logic [7:0] ctrl_rd;
  logic [7:0] test_rd;
  localparam logic [7:0] CTRL_RST = `SRS_RST_CTRL;
  localparam logic [7:0] TEST_RST = `SRS_RST_TEST;

  // reserved bits are constants in the read path, so writes cannot reach them
  assign ctrl_rd = {1'b0, hide, ovl_s, switch_en, 1'b0, cpu_need_rng,
                    ready, 1'b1};
  assign test_rd = {under, over, low_sel, high_sel, test_en};

  always_comb begin
    rd_mux = 8'h00;
    if (hit_random) begin
      rd_mux = random_value;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_test) begin
      rd_mux = test_rd;
    end
  end

  // read data is caught in the wait cycle and stands through the ack edge
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (av_req.read && !ack) begin
      readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------------
  // random value and ready flag
  // ----------------------------------------------------------------------
  // a fresh value from the source beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      random_value <= `SRS_RST_RANDOM;
    end else if (rng_valid) begin
      random_value <= rng_data;
    end else if (wr_random) begin
      random_value <= av_req.writedata[7:0];
    end
  end

  // set wins over the read clear and over a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= CTRL_RST[`SRS_CTRL_READY];
    end else if (rng_valid) begin
      ready <= 1'b1;
    end else if (rd_random) begin
      ready <= 1'b0;
    end else if (wr_ctrl) begin
      ready <= av_req.writedata[`SRS_CTRL_READY];
    end
  end

  assign rng_run = cpu_need_rng | contactless_interface_unit_rng_req;

  // ----------------------------------------------------------------------
  // control register: run force, supply switch, signal hiding
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_need_rng <= CTRL_RST[`SRS_CTRL_RUN];
      switch_en <= CTRL_RST[`SRS_CTRL_SWITCH];
      hide <= CTRL_RST[`SRS_CTRL_HIDE];
    end else if (wr_ctrl) begin
      cpu_need_rng <= av_req.writedata[`SRS_CTRL_RUN];
      switch_en <= av_req.writedata[`SRS_CTRL_SWITCH];
      hide <= av_req.writedata[`SRS_CTRL_HIDE];
    end
  end

  assign supply_switch_en = switch_en;

  // hide is on after reset so the pads stay masked until software clears control bit 6
  always_comb begin
    pads_int.secure_chip_signal_input = pads_s.secure_chip_signal_input;
    pads_int.auxiliary_port_pin = pads_s.auxiliary_port_pin;
    if (hide) begin
      pads_int.secure_chip_signal_input = 1'b0;
      pads_int.auxiliary_port_pin = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // antenna self test
  // ----------------------------------------------------------------------
  localparam logic [31:0] LOW_TAB = `SRS_LOW_THR;
  localparam logic [63:0] HIGH_TAB = `SRS_HIGH_THR;
  logic [7:0] low_thr;
  logic [7:0] high_thr;

  assign low_thr = LOW_TAB[{low_sel, 3'h0} +: 8];
  assign high_thr = HIGH_TAB[{high_sel, 3'h0} +: 8];

  always_ff @(posedge clk) begin
    if (rst) begin
      test_en <= TEST_RST[`SRS_TEST_EN];
      low_sel <= TEST_RST[`SRS_TEST_LOW_LSB +: 2];
      high_sel <= TEST_RST[`SRS_TEST_HIGH_LSB +: 3];
    end else if (wr_test) begin
      test_en <= av_req.writedata[`SRS_TEST_EN];
      low_sel <= av_req.writedata[`SRS_TEST_LOW_LSB +: 2];
      high_sel <= av_req.writedata[`SRS_TEST_HIGH_LSB +: 3];
    end
  end

  // flags are sticky while the test runs and clear once it is disabled;
  // they are visible only in the register, no pin carries them
  always_ff @(posedge clk) begin
    if (rst) begin
      under <= 1'b0;
      over <= 1'b0;
    end else if (!test_en) begin
      under <= 1'b0;
      over <= 1'b0;
    end else begin
      under <= under | (cur_s < low_thr);
      over <= over | (cur_s > high_thr);
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_TEST_OFF: assert property (@(posedge clk) disable iff (rst)
    !test_en |=> !under && !over)
    else $error("flags not cleared while test disabled");

  AST_UNDER: assert property (@(posedge clk) disable iff (rst)
    test_en && cur_s < low_thr |=> under)
    else $error("under-current flag missed");

  AST_OVER: assert property (@(posedge clk) disable iff (rst)
    test_en && cur_s > high_thr |=> over)
    else $error("over-current flag missed");

  AST_LOW_TAB: assert property (@(posedge clk) disable iff (rst)
    (low_sel == 2'h0 |-> low_thr == 8'h06) and
    (low_sel == 2'h3 |-> low_thr == 8'h28))
    else $error("low threshold wrong");

  AST_HIGH_TAB: assert property (@(posedge clk) disable iff (rst)
    (high_sel == 3'h0 |-> high_thr == 8'h26) and
    (high_sel == 3'h7 |-> high_thr == 8'h7F))
    else $error("high threshold wrong");

  AST_RNG_LOAD: assert property (@(posedge clk) disable iff (rst)
    rng_valid |=> random_value == $past(rng_data))
    else $error("random value not loaded");

  AST_READY_SET: assert property (@(posedge clk) disable iff (rst)
    rng_valid |=> ctrl_rd[`SRS_CTRL_READY])
    else $error("ready flag not set by fresh value");

  AST_READY_CLR: assert property (@(posedge clk) disable iff (rst)
    rd_random && !rng_valid |=> !ready)
    else $error("ready flag not cleared by read");

  AST_RUN: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_need_rng) |-> rng_run ##1 (rng_run || !cpu_need_rng))
    else $error("source not forced to run");

  AST_HIDE: assert property (@(posedge clk) disable iff (rst)
    hide |-> !pads_int.secure_chip_signal_input &&
             pads_int.auxiliary_port_pin)
    else $error("hidden pad copies not idle");

  AST_SWITCH: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> supply_switch_en == $past(av_req.writedata[4]))
    else $error("supply switch does not follow write");

  AST_RSVD: assert property (@(posedge clk) disable iff (rst)
    av_req.read && !ack && hit_ctrl |=>
      readdata[0] && !readdata[3] && !readdata[7])
    else $error("reserved control bits read wrong");

  AST_WAIT: assert property (@(posedge clk) disable iff (rst)
    req && !ack |-> av_rsp.waitrequest ##1 !av_rsp.waitrequest)
    else $error("slave did not answer after one wait cycle");

endmodule // srs_ctrl

// >>> srs_ctrl_tb_top.sv
// testbench for the self-test, random and supply-switch register bank
`timescale 1ns/10ps
module srs_ctrl_tb_top;
  import srs_pkg::*;
  localparam logic [17:0] A_RND = 18'h18414;
  localparam logic [17:0] A_CTL = 18'h18418;
  localparam logic [17:0] A_TST = 18'h18430;
  localparam logic [17:0] A_BAD = 18'h18420;
  logic clk, rst, rng_valid, cu_req, rng_run, ovl, sw_en;
  logic [7:0] cur, rng_data;
  srs_av_req_s av_req;
  srs_av_rsp_s av_rsp;
  srs_pads_s pads, pads_int;
  int error_cnt, num_checks;
  logic [31:0] q;
  logic [7:0] lo_thr [4] = '{8'h06, 8'h12, 8'h1D, 8'h28};
  logic [7:0] hi_thr [8] = '{8'h26, 8'h32, 8'h40, 8'h4C, 8'h59, 8'h66,
    8'h73, 8'h7F};
  srs_ctrl dut_u (.clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .transmitter_supply_ma(cur), .rng_data(rng_data),
    .rng_valid(rng_valid), .contactless_interface_unit_rng_req(cu_req),
    .rng_run(rng_run), .pads(pads), .pads_int(pads_int),
    .switch_overload(ovl), .supply_switch_en(sw_en));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic wr, input logic [17:0] a,
      input logic [7:0] d, output logic [31:0] r);
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= {24'h000000, d};
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (av_rsp.waitrequest !== 1'b0);
    r = av_rsp.readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // flags are sticky, so the test is disabled before the current moves
  task automatic st(input logic [7:0] cfg, input logic [7:0] c,
      input logic [7:0] e);
    bus(1'b1, A_TST, 8'h00, q);
    cur <= c;
    tick(3);
    bus(1'b1, A_TST, cfg, q);
    tick(3);
    bus(1'b0, A_TST, 8'h00, q);
    chk("selftest", {24'h000000, e}, q);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ctrl reset", 32'h41, q);
    bus(1'b0, A_TST, 8'h00, q);
    chk("test reset", 32'h00, q);
    chk("pads forced", 2'b01, pads_int);
    chk("switch off", 1'b0, sw_en);
  endtask
  task automatic t_ctrl;
    bus(1'b1, A_CTL, 8'hFF, q);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ctrl ones", 32'h57, q);
    chk("switch on", 1'b1, sw_en);
    chk("run forced", 1'b1, rng_run);
    chk("pads hidden", 2'b01, pads_int);
    // supply goes off while the pads are still hidden
    bus(1'b1, A_CTL, 8'h40, q);
    chk("hidden at switch off", 32'h1, pads_int);
    chk("switch off hidden", 32'h0, sw_en);
    bus(1'b1, A_CTL, 8'h00, q);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ctrl zeros", 32'h01, q);
    chk("switch off", 1'b0, sw_en);
    chk("run idle", 1'b0, rng_run);
    cu_req <= 1'b1;
    tick(1);
    chk("run by unit", 1'b1, rng_run);
    cu_req <= 1'b0;
    chk("pads follow", 2'b10, pads_int);
    ovl <= 1'b1;
    tick(3);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("overload", 32'h21, q);
    ovl <= 1'b0;
    bus(1'b1, A_CTL, 8'h40, q);
  endtask
  task automatic t_rng;
    rng_data <= 8'hA5;
    rng_valid <= 1'b1;
    tick(1);
    rng_valid <= 1'b0;
    tick(1);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ready set", 32'h43, q);
    bus(1'b0, A_RND, 8'h00, q);
    chk("random", 32'hA5, q);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ready clear", 32'h41, q);
    bus(1'b1, A_RND, 8'h3C, q);
    bus(1'b0, A_RND, 8'h00, q);
    chk("random write", 32'h3C, q);
    bus(1'b1, A_BAD, 8'hFF, q);
    bus(1'b0, A_BAD, 8'h00, q);
    chk("unmapped", 32'h00, q);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ctrl intact", 32'h41, q);
  endtask
  task automatic t_self;
    for (int l = 0; l < 4; l++) begin
      st({2'b00, l[1:0], 4'hF}, lo_thr[l], {2'b00, l[1:0], 4'hF});
      st({2'b00, l[1:0], 4'hF}, lo_thr[l] - 8'h01,
        {2'b10, l[1:0], 4'hF});
    end
    for (int h = 0; h < 8; h++) begin
      st({4'h0, h[2:0], 1'b1}, hi_thr[h], {4'h0, h[2:0], 1'b1});
      st({4'h0, h[2:0], 1'b1}, hi_thr[h] + 8'h01,
        {4'h4, h[2:0], 1'b1});
    end
    st(8'h0E, 8'h00, 8'h0E);
    bus(1'b1, A_TST, 8'h00, q);
    bus(1'b0, A_TST, 8'h00, q);
    chk("test cleared", 32'h00, q);
  endtask
  // reset in mid-run must bring the control and test fields back to their reset values
  task automatic t_rst;
    bus(1'b1, A_CTL, 8'hFF, q);
    bus(1'b1, A_TST, 8'h0F, q);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    bus(1'b0, A_CTL, 8'h00, q);
    chk("ctrl after reset", 32'h41, q);
    bus(1'b0, A_TST, 8'h00, q);
    chk("test after reset", 32'h00, q);
    chk("switch after reset", 32'h0, sw_en);
    chk("pads after reset", 32'h1, pads_int);
  endtask
  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // the whole run needs about five hundred cycles
  initial begin
    tick(20000);
    error_cnt++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    av_req = '0;
    cur = 8'h00;
    rng_data = 8'h00;
    rng_valid = 1'b0;
    cu_req = 1'b0;
    ovl = 1'b0;
    pads = 2'b10;
    error_cnt = 0;
    num_checks = 0;
    av_req.byteenable = 4'hF;
    tick(12);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_ctrl();
    t_rng();
    t_self();
    t_rst();
    final_report();
  end
endmodule // srs_ctrl_tb_top
